/* File: rtl/ppm_prescaler.sv */
/*
  peripheral prescaler and power-down mode control, with its register file.
  assumes core_clk is the oscillator clock and runs through every mode; the
  stopped system clock is shown by sys_clk_en, a one-cycle enable per tick.
  assumes a register port master of the plain strobe kind, a one-cycle
  sleep_req pulse from the processor and a wake_req from the wake logic.
  peripherals gate themselves from psc_taps, module_run and periph_run.
*/
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps

module ppm_prescaler
  import ppm_pkg::*;
#(
  parameter int PSC_W = PPM_PSC_W
)(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire ppm_bus_type       bus,
  output logic [7:0]             rdata,
  input  wire logic              sleep_req,
  input  wire logic              wake_req,
  output logic [PSC_W-1:0]       psc_taps,
  output logic                   sys_clk_en,
  output logic                   cpu_run,
  output logic                   periph_run,
  output logic [15:0]            module_run,
  output logic                   port_hold,
  output logic [1:0]             power_mode
);

  // ===========================================================
  // registers
  logic [7:0]        spc1_r;
  logic [7:0]        spc2_r;
  logic [7:0]        msc1_r;
  logic [7:0]        msc2_r;
  logic [PSC_W-1:0]  psc_r;
  logic [5:0]        div_r;
  logic              div_tick;
  ppm_mode_type      mode_r;
  ppm_state_type     state_r;
  logic [PPM_WAIT_W-1:0] wait_r;
  logic              clk_stop;

  // ===========================================================
  // register file
  // writes are taken only while clk_en is high; unmapped addresses are ignored
  // low nibble of system_power_control_1 is reserved and reads as zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      spc1_r <= PPM_SPC1_RST;
      spc2_r <= PPM_SPC2_RST;
    end
    else if (clk_en && bus.wr)
    begin
      if (bus.addr == PPM_ADDR_SPC1)
        spc1_r <= {bus.wdata[7:4], 4'h0};
      if (bus.addr == PPM_ADDR_SPC2)
        spc2_r <= bus.wdata;
    end
  end

  // a set module bit stops that module; clearing it lets the module run again
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      msc1_r <= PPM_MSC_RST;
      msc2_r <= PPM_MSC_RST;
    end
    else if (clk_en && bus.wr)
    begin
      if (bus.addr == PPM_ADDR_MSC1)
        msc1_r <= bus.wdata;
      if (bus.addr == PPM_ADDR_MSC2)
        msc2_r <= bus.wdata;
    end
  end

  // the count is deliberately absent from the read map
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (clk_en)
    begin
      rdata <= 8'h00;
      if (bus.rd)
      begin
        case (bus.addr)
          PPM_ADDR_SPC1: rdata <= spc1_r;
          PPM_ADDR_SPC2: rdata <= spc2_r;
          PPM_ADDR_MSC1: rdata <= msc1_r;
          PPM_ADDR_MSC2: rdata <= msc2_r;
          PPM_ADDR_STAT: rdata <= {4'h0, state_r, mode_r};
          default:       rdata <= 8'h00;
        endcase
      end
    end
  end

  // ===========================================================
  // power mode sequencer
  // a sleep request is only honoured in RUN and a wake only in HALT, so a
  // stray strobe in the other states cannot reorder the sequence
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= PPM_RUN;
      mode_r  <= PPM_ACTIVE;
    end
    else if (clk_en)
    begin
      case (state_r)
        PPM_RUN:
          if (sleep_req)
          begin
            state_r <= PPM_HALT;
            if (spc1_r[PPM_SOFTWARE_STANDBY_SELECT_BIT])
              mode_r <= PPM_STANDBY;
            else if (spc2_r[PPM_SUBSLP_BIT])
              mode_r <= PPM_SUBSLEEP;
            else
              mode_r <= PPM_SLEEP;
          end
        PPM_HALT:
          if (wake_req)
          begin
            // sleep keeps the clock alive, so no stabilization wait is owed
            if (mode_r == PPM_SLEEP)
            begin
              state_r <= PPM_RUN;
              mode_r  <= PPM_ACTIVE;
            end
            else
              state_r <= PPM_WAIT;
          end
        PPM_WAIT:
          if (wait_r == 18'h0)
          begin
            state_r <= PPM_RUN;
            mode_r  <= PPM_ACTIVE;
          end
        default:
        begin
          state_r <= PPM_RUN;
          mode_r  <= PPM_ACTIVE;
        end
      endcase
    end
  end

  // wait counter, loaded on a wake from a clock-stopping mode and counted
  // on core_clk, the oscillator clock; the longest count needs 18 bits
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      wait_r <= '0;
    else if (clk_en)
    begin
      if (state_r == PPM_HALT && wake_req && mode_r != PPM_SLEEP)
        wait_r <= ppm_wait_count(spc1_r[PPM_STS_HI:PPM_STS_LO]) - 18'h1;
      else if (state_r == PPM_WAIT && wait_r != 18'h0)
        wait_r <= wait_r - 18'h1;
    end
  end

  // clock stays stopped through the wait so peripherals see no early edges
  assign clk_stop = (mode_r == PPM_STANDBY) || (mode_r == PPM_SUBSLEEP);

  // ===========================================================
  // system clock divider and prescaler
  // the divider restarts on every tick, so a new ratio takes hold within one
  // period of the new one
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      div_r <= '0;
    else if (clk_en)
    begin
      if (clk_stop || div_tick)
        div_r <= '0;
      else
        div_r <= div_r + 6'h1;
    end
  end

  assign div_tick = ((div_r & ppm_div_mask(spc2_r[PPM_DIV_HI:PPM_DIV_LO])) ==
                     ppm_div_mask(spc2_r[PPM_DIV_HI:PPM_DIV_LO]));

  // free-running and wrapping, so every tap keeps toggling while clocked
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      psc_r <= PSC_W'(PPM_PSC_RST);
    else if (clk_en)
    begin
      if (clk_stop)
        psc_r <= PSC_W'(PPM_PSC_RST);
      else if (div_tick)
        psc_r <= psc_r + 1'b1;
    end
  end

  // ===========================================================
  // outputs, one register per concern so each stays a plain flip-flop
  // taps are cleared in the same edge that stops the clock, so no
  // peripheral ever sees a stale count beside a stopped clock
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      psc_taps <= '0;
    else if (clk_en)
      psc_taps <= clk_stop ? PSC_W'(PPM_PSC_RST) : psc_r;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sys_clk_en <= 1'b0;
    else if (clk_en)
      sys_clk_en <= !clk_stop && div_tick;
  end

  // the processor runs only in RUN; peripherals also idle through the wait
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cpu_run    <= 1'b0;
      periph_run <= 1'b0;
    end
    else if (clk_en)
    begin
      cpu_run    <= (state_r == PPM_RUN);
      periph_run <= !clk_stop;
    end
  end

  // the global stop overrides every module bit
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      module_run <= '0;
    else if (clk_en)
      module_run <= clk_stop ? 16'h0000 : ~{msc2_r, msc1_r};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      port_hold  <= 1'b0;
      power_mode <= PPM_ACTIVE;
    end
    else if (clk_en)
    begin
      port_hold  <= (mode_r == PPM_SUBSLEEP);
      power_mode <= mode_r;
    end
  end

endmodule : ppm_prescaler

/* File: rtl/ppm_pkg.sv */
/*
  package of the prescaler and power-mode block: register offsets, field
  positions, reset values, mode and state encodings, wait-count decode.
  assumes nothing of its surroundings.
*/
package ppm_pkg;

  // ===========================================================
  // register map
  localparam logic [3:0] PPM_ADDR_SPC1 = 4'h0;
  localparam logic [3:0] PPM_ADDR_SPC2 = 4'h1;
  localparam logic [3:0] PPM_ADDR_MSC1 = 4'h2;
  localparam logic [3:0] PPM_ADDR_MSC2 = 4'h3;
  localparam logic [3:0] PPM_ADDR_STAT = 4'h4;

  // ===========================================================
  // field positions of system_power_control_1
  localparam int PPM_SOFTWARE_STANDBY_SELECT_BIT = 7;
  localparam int PPM_STS_HI   = 6;
  localparam int PPM_STS_LO   = 4;
  // field positions of system_power_control_2
  localparam int PPM_SUBSLP_BIT = 7;
  localparam int PPM_DIV_HI     = 2;
  localparam int PPM_DIV_LO     = 0;

  // ===========================================================
  // reset values
  localparam logic [7:0]  PPM_SPC1_RST = 8'h00;
  localparam logic [7:0]  PPM_SPC2_RST = 8'h00;
  localparam logic [7:0]  PPM_MSC_RST  = 8'h00;
  localparam logic [12:0] PPM_PSC_RST  = 13'h0000;
  localparam int          PPM_PSC_W    = 13;
  localparam int          PPM_WAIT_W   = 18;

  // ===========================================================
  // power modes, gray coded along active-sleep-standby-subsleep
  typedef enum logic [1:0] {
    PPM_ACTIVE   = 2'b00,
    PPM_SLEEP    = 2'b01,
    PPM_STANDBY  = 2'b11,
    PPM_SUBSLEEP = 2'b10
  } ppm_mode_type;

  typedef enum logic [1:0] {
    PPM_RUN  = 2'b00,
    PPM_HALT = 2'b01,
    PPM_WAIT = 2'b11
  } ppm_state_type;

  // register bus request bundle
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ppm_bus_type;

  // stabilization wait in states, decoded from the three select bits
  function automatic logic [17:0] ppm_wait_count(input logic [2:0] sel);
    case (sel)
      3'h0:    ppm_wait_count = 18'h02000;
      3'h1:    ppm_wait_count = 18'h04000;
      3'h2:    ppm_wait_count = 18'h08000;
      3'h3:    ppm_wait_count = 18'h10000;
      3'h4:    ppm_wait_count = 18'h20000;
      3'h5:    ppm_wait_count = 18'h00400;
      3'h6:    ppm_wait_count = 18'h00080;
      default: ppm_wait_count = 18'h00010;
    endcase
  endfunction : ppm_wait_count

  // system clock divide ratio as a mask over a 6-bit divider
  function automatic logic [5:0] ppm_div_mask(input logic [2:0] sel);
    case (sel)
      3'h4:    ppm_div_mask = 6'h07;
      3'h5:    ppm_div_mask = 6'h0f;
      3'h6:    ppm_div_mask = 6'h1f;
      3'h7:    ppm_div_mask = 6'h3f;
      default: ppm_div_mask = 6'h00;
    endcase
  endfunction : ppm_div_mask

endpackage : ppm_pkg

/* File: test/ppm_prescaler_assertions.sv */
/*
  port checker of the prescaler and power-mode block.
  assumes it is bound onto ppm_prescaler with one clock domain.
*/
`timescale 1ns/1ps
module ppm_prescaler_assertions
  import ppm_pkg::*;
#(
  parameter int PSC_W = PPM_PSC_W
)(
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             clk_en,
  input wire ppm_bus_type      bus,
  input wire logic [7:0]       rdata,
  input wire logic             sleep_req,
  input wire logic             wake_req,
  input wire logic [PSC_W-1:0] psc_taps,
  input wire logic             sys_clk_en,
  input wire logic             cpu_run,
  input wire logic             periph_run,
  input wire logic [15:0]      module_run,
  input wire logic             port_hold,
  input wire logic [1:0]       power_mode
);
  // ==========================================================
  // port relations
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_rdata_idle: assert property ($past(clk_en) && !$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  a_stop_clear: assert property (!cpu_run && !periph_run |-> psc_taps == '0 && !sys_clk_en)
    else $error("prescaler not cleared while stopped");
  a_taps_step: assert property ($changed(psc_taps) |->
    psc_taps == '0 || psc_taps == $past(psc_taps) + 1'b1)
    else $error("prescaler skipped a count");
  a_sleep_periph: assert property (power_mode == PPM_SLEEP |-> !cpu_run && periph_run)
    else $error("sleep run flags wrong");
  a_standby_halt: assert property (power_mode == PPM_STANDBY |-> !cpu_run && !periph_run)
    else $error("standby run flags wrong");
  a_subsleep_hold: assert property (power_mode == PPM_SUBSLEEP |->
    port_hold && !cpu_run && !periph_run)
    else $error("subsleep flags wrong");
  a_module_off: assert property (!periph_run |-> module_run == 16'h0000)
    else $error("module clock runs while stopped");
  a_sleep_entry: assert property (cpu_run && sleep_req && clk_en |-> ##2 !cpu_run)
    else $error("sleep request not taken");
  a_run_active: assert property (cpu_run |-> power_mode == PPM_ACTIVE && !port_hold)
    else $error("running outside active mode");
  c_sleep: cover property (power_mode == PPM_SLEEP);
  c_standby: cover property (power_mode == PPM_STANDBY);
  c_wrap: cover property ($past(psc_taps) != '0 && psc_taps == '0);
endmodule : ppm_prescaler_assertions

bind ppm_prescaler ppm_prescaler_assertions #(.PSC_W(PSC_W)) chk_u (.core_clk(core_clk),
  .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata), .sleep_req(sleep_req),
  .wake_req(wake_req), .psc_taps(psc_taps), .sys_clk_en(sys_clk_en), .cpu_run(cpu_run),
  .periph_run(periph_run), .module_run(module_run), .port_hold(port_hold),
  .power_mode(power_mode));

/* File: test/ppm_prescaler_test.sv */
/*
  self-checking bench of the prescaler and power-mode block.
  assumes the checker file is compiled beside it.
*/
`timescale 1ns/1ps
module ppm_prescaler_test
  import ppm_pkg::*;
;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic         clk_en = 1'b1;
  ppm_bus_type  bus = '0;
  logic         sleep_req = 1'b0;
  logic         wake_req = 1'b0;
  logic [7:0]   rdata;
  logic [12:0]  psc_taps;
  logic         sys_clk_en, cpu_run, periph_run, port_hold;
  logic [15:0]  module_run;
  logic [1:0]   power_mode;
  logic [31:0]  rng = 32'h5a;
  int           err_total = 0, total_checks = 0, cycles = 0;
  ppm_mode_type md [3] = '{PPM_SLEEP, PPM_STANDBY, PPM_SUBSLEEP};

  always #12.5 core_clk = ~core_clk;

  ppm_prescaler dut_u (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .bus(bus),
    .rdata(rdata), .sleep_req(sleep_req), .wake_req(wake_req), .psc_taps(psc_taps),
    .sys_clk_en(sys_clk_en), .cpu_run(cpu_run), .periph_run(periph_run),
    .module_run(module_run), .port_hold(port_hold), .power_mode(power_mode));

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  function automatic int ratio(input int c);
    return (c < 4) ? 1 : (8 << (c - 4));
  endfunction : ratio
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // settle past the edge so registered outputs are read after they land
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus <= '0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask : rd

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 40000)
    begin
      err_total++;
      print_verdict();
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    logic [7:0]  d;
    logic [12:0] t0, dt;
    logic [2:0]  s;
    int          n, w;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    chk("taps at release", 16'h0, 16'(psc_taps));
    tick(1);
    chk("taps first count", 16'h1, 16'(psc_taps));
    for (int a = 0; a < 5; a++)
    begin
      rd(a[3:0], d);
      chk("reset value", 16'h0, 16'(d));
    end
    for (int i = 0; i < 4; i++)
    begin
      rng = xs(rng);
      wr(PPM_ADDR_SPC1, rng[7:0]);
      rd(PPM_ADDR_SPC1, d);
      chk("spc1", 16'({rng[7:4], 4'h0}), 16'(d));
    end
    wr(4'hf, 8'hff);
    rd(4'hf, d);
    chk("unmapped", 16'h0, 16'(d));
    rng = xs(rng);
    wr(PPM_ADDR_MSC1, rng[7:0]);
    wr(PPM_ADDR_MSC2, rng[15:8]);
    tick(1);
    chk("module_run", ~rng[15:0], module_run);
    wr(PPM_ADDR_MSC1, 8'h00);
    wr(PPM_ADDR_MSC2, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(PPM_ADDR_SPC2, 8'(c));
      tick(4);
      t0 = psc_taps;
      n = 0;
      repeat (128)
      begin
        tick(1);
        n += int'(sys_clk_en);
      end
      dt = psc_taps - t0;
      chk("clock ticks", 16'(128 / ratio(c)), 16'(n));
      chk("taps advance", 16'(128 / ratio(c)), 16'(dt));
    end
    wr(PPM_ADDR_SPC2, 8'h00);
    @(posedge core_clk);
    clk_en <= 1'b0;
    tick(1);
    t0 = psc_taps;
    tick(8);
    chk("frozen", 16'(t0), 16'(psc_taps));
    @(posedge core_clk);
    clk_en <= 1'b1;
    n = 0;
    while (psc_taps !== 13'h1fff && n < 9000)
    begin
      tick(1);
      n++;
    end
    tick(1);
    chk("wrap", 16'h0, 16'(psc_taps));
    for (int m = 0; m < 3; m++)
    begin
      rng = xs(rng);
      s = {2'b11, rng[0]};
      w = s[0] ? 16 : 128;
      wr(PPM_ADDR_SPC1, {m == 1, s, 4'h0});
      wr(PPM_ADDR_SPC2, {m == 2, 7'h00});
      @(posedge core_clk);
      sleep_req <= 1'b1;
      @(posedge core_clk);
      sleep_req <= 1'b0;
      tick(3);
      chk("mode", 16'(md[m]), 16'(power_mode));
      chk("run flags", 16'({m == 0, m == 2}), 16'({cpu_run, periph_run, port_hold}));
      if (m > 0)
        chk("taps stopped", 16'h0, 16'(psc_taps));
      @(posedge core_clk);
      wake_req <= 1'b1;
      @(posedge core_clk);
      wake_req <= 1'b0;
      n = 0;
      while (cpu_run !== 1'b1 && n < 300)
      begin
        tick(1);
        n++;
      end
      chk("wake wait", 16'h1, 16'(m == 0 ? n <= 4 : (n >= w && n <= w + 4)));
      chk("active", 16'(PPM_ACTIVE), 16'(power_mode));
    end
    print_verdict();
  end
endmodule : ppm_prescaler_test
